// [tb_top.sv]
/*
  Self-checking bench: host and sensor joined by the link, compared
  with a model of the sensor registers after every transfer.
  Assumes package, header, design and link checker compile first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tsn_defines.svh"

module tb_top;
  // stimulus and observed outputs
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic addressSelectHigh = 1'b0;
  logic addressSelectLow = 1'b1;
  logic [9:0] convResult = 10'h000;
  logic convDone = 1'b0;
  logic [31:0] regRData, rdv;
  logic [7:0] temperature;
  logic convRun, standby, dataReady;
  // model state and bookkeeping
  int fail_count = 0;
  int checked = 0;
  int seed = 33;
  int mTemp = 0, mStby = 0, mRdy = 0, mPtr = 0;
  int myAddr = 'h4d, tgt = 'h4d;
  int convQ[$] = '{'h07f, 'h080, 'h3ff, 'h380, 'h37f, 'h200, 'h019};

  // system clock
  always #4 clock = ~clock;

  tsn_link_if link ();
  tsn_host i_tsn_host (.clock(clock), .sys_rst(sys_rst), .link(link),
    .regAddr(regAddr), .regWData(regWData), .regWrite(regWrite),
    .regRead(regRead), .regRData(regRData));
  tsn_slave i_tsn_slave (.clock(clock), .sys_rst(sys_rst), .link(link),
    .addressSelectHigh(addressSelectHigh),
    .addressSelectLow(addressSelectLow), .convResult(convResult),
    .convDone(convDone), .convRun(convRun), .temperature(temperature),
    .standby(standby), .dataReady(dataReady));
  tsn_link_chk i_tsn_link_chk (.clock(clock), .sys_rst(sys_rst),
    .scl(link.scl), .hostSdaOut(link.hostSdaOut),
    .hostSdaEnN(link.hostSdaEnN), .devSdaOut(link.devSdaOut),
    .devSdaEnN(link.devSdaEnN), .sda(link.sda));

  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic give_verdict();
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // register port cycles
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRData;
  endtask

  task automatic ports();
    #1;
    chk("temperature", mTemp, temperature);
    chk("standby", mStby, standby);
    chk("ready", mRdy, dataReady);
    chk("convRun", !mStby, convRun);
  endtask

  // converter pulse; clamps out-of-range counts
  task automatic conv(input logic [9:0] r);
    int v = $signed(r);
    @(posedge clock);
    convResult <= r;
    convDone <= 1'b1;
    @(posedge clock);
    convDone <= 1'b0;
    if (mStby == 0)
    begin
      mRdy = 1;
      mTemp = (v > 127 ? 127 : v < -128 ? -128 : v) & 255;
    end
    repeat (2) @(posedge clock);
    ports();
  endtask

  // launch a transfer and poll until the host is idle
  task automatic xfer(input int ctl, input int nk, input int by);
    int n = 0;
    wr(`TSN_HREG_CTRL, ctl);
    do
    begin
      rd(`TSN_HREG_STATUS, rdv);
      n++;
    end while (rdv[8] !== 1'b0 && n < 3000);
    chk("busy", 0, rdv[8]);
    chk("nack", nk, rdv[9]);
    if (by >= 0) chk("byte", by, rdv[7:0]);
  endtask

  // transfer kind: 0 write, 1 read with command, 2 bare read
  task automatic op(input int kind, input int cmd, input int dat);
    int nk = 0;
    int by = -1;
    if (tgt != myAddr) nk = 1;
    else if (kind != 2 && cmd > 1) nk = 1;
    else
    begin
      if (kind != 2) mPtr = cmd;
      if (kind == 0 && cmd == 0) nk = 1;
      else if (kind == 0) mStby = dat >> 7 & 1;
      else by = mPtr ? mStby * 128 + mRdy * 64 : mTemp;
      if (mStby) mRdy = 0;
    end
    xfer((kind == 2 ? 'h20000 : 0) | (kind == 1 ? 'h10000 : 0) |
      dat << 8 | cmd, nk, by);
    ports();
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    ports();
    rd(`TSN_HREG_TARGET, rdv);
    chk("target", 'h4d, rdv);
    rd(4'hc, rdv);
    chk("unmapped", 0, rdv);
    op(2, 0, 0);
    op(1, 1, 0);
    repeat (6) convQ.push_back(xs() & 'h3ff);
    while (convQ.size() > 0)
    begin
      conv(10'(convQ.pop_front()));
      op(1, 0, 0);
    end
    op(2, 0, 0);
    op(0, 1, 'hff);
    op(1, 1, 0);
    conv(10'h01e);
    op(2, 0, 0);
    op(0, 1, 'h00);
    conv(10'h3e7);
    op(1, 1, 0);
    op(0, 0, 'h55);
    op(2, 0, 0);
    op(0, 2, 'h80);
    for (int s = 0; s < 8; s++)
    begin
      @(posedge clock);
      addressSelectHigh <= s[2];
      addressSelectLow <= s[1];
      myAddr = 'h4c + s / 2;
      tgt = myAddr ^ s[0];
      wr(`TSN_HREG_TARGET, tgt);
      repeat (4) @(posedge clock);
      op(1, 1, 0);
    end
    give_verdict();
  end

  // watchdog against a hung transfer
  initial
  begin
    repeat (90000) @(posedge clock);
    fail_count++;
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire

// [tsn_defines.svh]
/*
  Constants for the two-wire temperature sensor link: command codes,
  register fields, reset values, bus addresses and link timing counts.
  Assumes it is included by bare name after the package it serves.
*/
`ifndef TSN_DEFINES_SVH
`define TSN_DEFINES_SVH

// command bytes that select a sensor register
`define TSN_CMD_TEMP 8'h00
`define TSN_CMD_CFG 8'h01

// settings_and_status field positions
`define TSN_CFG_STANDBY 7
`define TSN_CFG_READY 6

// reset values of both sensor registers
`define TSN_RST_TEMP 8'h00
`define TSN_RST_CFG 8'h00

// upper five bits of the 7-bit bus address, and the default address
`define TSN_ADDR_FIXED 5'h13
`define TSN_ADDR_DEFAULT 7'h4d

// clamp limits for the converter result, 10-bit two's complement
`define TSN_TEMP_HI 10'h07f
`define TSN_TEMP_LO 10'h380

// host register byte offsets
`define TSN_HREG_CTRL 4'h0
`define TSN_HREG_TARGET 4'h4
`define TSN_HREG_STATUS 4'h8

// host control word fields
`define TSN_CTRL_READ 16
`define TSN_CTRL_RECV 17

// link timing: one serial clock period is four quarter steps
`define TSN_CLK_NS 8
`define TSN_SCL_NS 160
`define TSN_QTR_CYCLES (`TSN_SCL_NS / (4 * `TSN_CLK_NS))
`define TSN_QTR_LAST 3'(`TSN_QTR_CYCLES - 1)

`endif

// [tsn_host.sv]
/*
  Host end of the two-wire link: makes the serial clock from the
  system clock and runs write, read and bare-read transfers on order.
  Assumes software reaches it over the plain register port.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tsn_defines.svh"

module tsn_host
  import tsn_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic sys_rst,
  // two-wire link
  tsn_link_if.host link,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRData
);

  // byte sent in a given stage; the read byte is left released
  function automatic logic [7:0] stageByte(input tsn_stage_e s,
    input logic [6:0] tgt, input logic [7:0] cmd, input logic [7:0] dat);
    logic [7:0] b;
    case (s)
      ST_AW: b = {tgt, 1'b0};
      ST_CMD: b = cmd;
      ST_WD: b = dat;
      ST_AR: b = {tgt, 1'b1};
      default: b = 8'hff;
    endcase
    return b;
  endfunction

  tsn_host_state_e hState;
  tsn_host_state_e next_hState;
  tsn_stage_e stage;
  tsn_stage_e next_stage;
  logic [1:0] step;
  logic [2:0] qtrCnt;
  logic [3:0] bitIdx;
  logic [7:0] txShift;
  logic [7:0] next_txShift;
  logic [7:0] rxShift;
  logic [7:0] rxData;
  logic ackBit;
  logic sclHigh;
  logic sdaLow;
  logic next_sdaLow;
  logic nack;
  logic [6:0] target;
  logic [7:0] ctrlCmd;
  logic [7:0] ctrlData;
  logic opRead;
  logic sdaS;

  // data line crosses into the clock domain
  tsn_sync #(.W(1)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .din(link.sda),
    .dout(sdaS)
  );

  // decode of quarter steps and software orders
  wire busy = (hState != HS_IDLE);
  wire tick = busy & (qtrCnt == `TSN_QTR_LAST);
  wire launch = regWrite & (regAddr == `TSN_HREG_CTRL) & ~busy;
  wire lastStep = tick & (step == 2'h3);
  wire byteEnd = lastStep & (hState == HS_BYTE) & (bitIdx == 4'h8);

  // step sequencer: next state, stage and data drive
  always_comb
  begin
    next_hState = hState;
    next_stage = stage;
    next_txShift = txShift;
    next_sdaLow = sdaLow;
    if (launch)
    begin
      next_hState = HS_START;
      next_stage = regWData[`TSN_CTRL_RECV] ? ST_AR : ST_AW;
    end
    else if (tick)
    begin
      case (hState)
        HS_START:
        begin
          if (step == 2'h0)
            next_sdaLow = 1'b0;
          else if (step == 2'h2)
            next_sdaLow = 1'b1; // falls while clock high
          else if (step == 2'h3)
          begin
            next_hState = HS_BYTE;
            next_txShift = stageByte(stage, target, ctrlCmd, ctrlData);
          end
        end
        HS_BYTE:
        begin
          if (step == 2'h0)
            next_sdaLow = (bitIdx != 4'h8) & ~txShift[7];
          else if (step == 2'h3 && bitIdx != 4'h8)
            next_txShift = {txShift[6:0], 1'b1};
          else if (step == 2'h3)
          begin
            next_hState = HS_STOP;
            if (stage != ST_RD && !ackBit)
            begin
              next_hState = HS_BYTE;
              if (stage == ST_AW)
                next_stage = ST_CMD;
              else if (stage == ST_CMD && opRead)
              begin
                next_hState = HS_START;
                next_stage = ST_AR;
              end
              else if (stage == ST_CMD)
                next_stage = ST_WD;
              else if (stage == ST_AR)
                next_stage = ST_RD;
              else
                next_hState = HS_STOP;
              next_txShift = stageByte(next_stage, target, ctrlCmd,
                ctrlData);
            end
          end
        end
        HS_STOP:
        begin
          if (step == 2'h0)
            next_sdaLow = 1'b1;
          else if (step == 2'h2)
            next_sdaLow = 1'b0;
          else if (step == 2'h3)
            next_hState = HS_IDLE;
        end
        default:
        begin
          next_hState = HS_IDLE;
        end
      endcase
    end
  end

  // bit engine registers
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hState <= HS_IDLE;
      stage <= ST_AW;
      txShift <= 8'hff;
      sdaLow <= 1'b0;
      qtrCnt <= 3'h0;
      step <= 2'h0;
      bitIdx <= 4'h0;
      sclHigh <= 1'b1;
    end
    else
    begin
      hState <= next_hState;
      stage <= next_stage;
      txShift <= next_txShift;
      sdaLow <= next_sdaLow;
      qtrCnt <= (tick || !busy) ? 3'h0 : qtrCnt + 3'h1;
      if (launch || lastStep)
        step <= 2'h0;
      else if (tick)
        step <= step + 2'h1;
      if (launch || byteEnd || (lastStep && hState != HS_BYTE))
        bitIdx <= 4'h0;
      else if (lastStep)
        bitIdx <= bitIdx + 4'h1;
      if (tick && step == 2'h1)
        sclHigh <= 1'b1;
      else if (tick && step == 2'h3 && hState != HS_STOP)
        sclHigh <= 1'b0;
    end
  end

  // sampling with clock high, order capture and status
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rxShift <= 8'h00;
      rxData <= 8'h00;
      ackBit <= 1'b0;
      nack <= 1'b0;
      target <= `TSN_ADDR_DEFAULT;
      ctrlCmd <= 8'h00;
      ctrlData <= 8'h00;
      opRead <= 1'b0;
      regRData <= 32'h0;
    end
    else
    begin
      if (tick && step == 2'h2 && hState == HS_BYTE)
      begin
        if (bitIdx == 4'h8)
          ackBit <= sdaS;
        else
          rxShift <= {rxShift[6:0], sdaS};
      end
      if (byteEnd && stage == ST_RD)
        rxData <= rxShift;
      if (byteEnd && stage != ST_RD && ackBit)
        nack <= 1'b1;
      if (launch)
      begin
        nack <= 1'b0;
        ctrlCmd <= regWData[7:0];
        ctrlData <= regWData[15:8];
        opRead <= regWData[`TSN_CTRL_READ];
      end
      if (regWrite && regAddr == `TSN_HREG_TARGET)
        target <= regWData[6:0];
      if (regRead && regAddr == `TSN_HREG_TARGET)
        regRData <= {25'h0, target};
      else if (regRead && regAddr == `TSN_HREG_STATUS)
        regRData <= {22'h0, nack, busy, rxData};
      else
        regRData <= 32'h0;
    end
  end

  // open-drain data and host-made clock
  assign link.scl = sclHigh;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaEnN = ~sdaLow;

endmodule // tsn_host

`default_nettype wire

// [tsn_link_chk.sv]
/*
  Checker for the two-wire link: bit position tracking and timing
  relations between the host and the sensor ends.
  Assumes the bench instantiates it beside the link interface.
*/
`timescale 1ns/1ns
`default_nettype none

module tsn_link_chk (
  // system
  input wire logic clock,
  input wire logic sys_rst,
  // link signals
  input wire logic scl,
  input wire logic hostSdaOut,
  input wire logic hostSdaEnN,
  input wire logic devSdaOut,
  input wire logic devSdaEnN,
  input wire logic sda
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  logic sclQ, sdaQ, rw, first, idle, deaf;
  logic [3:0] cnt;

  // line events seen against the previous sample
  wire startSeen = sclQ & scl & sdaQ & ~sda;
  wire stopSeen = sclQ & scl & ~sdaQ & sda;
  wire sclRise = ~sclQ & scl;
  wire sclFall = sclQ & ~scl;
  wire hiHeld = sclQ & scl;

  // previous line levels, idle high
  always_ff @(posedge clock)
  begin
    sclQ <= sys_rst | scl;
    sdaQ <= sys_rst | sda;
  end

  // bit slot (1..9), direction and first-byte tracking
  always_ff @(posedge clock)
  begin
    if (sys_rst | startSeen)
    begin
      cnt <= 4'h0;
      rw <= 1'b0;
      first <= 1'b1;
      deaf <= 1'b0;
    end
    else if (sclRise)
    begin
      cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
      if (first && cnt == 4'h7) rw <= sda;
      if (first && cnt == 4'h8) deaf <= sda;
      if (cnt == 4'h9) first <= 1'b0;
    end
  end

  // bus idle between stop and start
  always_ff @(posedge clock)
  begin
    if (sys_rst | stopSeen) idle <= 1'b1;
    else if (startSeen) idle <= 1'b0;
  end

  chk_drive_low: assert property (~hostSdaOut & ~devSdaOut)
    else $error("link end drives data high");
  chk_ack_owner: assert property
    (hiHeld && cnt == 4'h9 && (first || !rw) && !sda |-> !devSdaEnN)
    else $error("ack low not driven by sensor");
  chk_quiet_idle: assert property (idle |-> devSdaEnN)
    else $error("sensor drives data on idle bus");
  chk_no_early_pull: assert property
    (hiHeld && !rw && cnt != 4'h9 |-> devSdaEnN)
    else $error("sensor pulls data outside ack slot");
  chk_nack_silent: assert property (deaf |-> devSdaEnN)
    else $error("sensor drives after address mismatch");
  chk_dev_steady: assert property (hiHeld |-> $stable(devSdaEnN))
    else $error("sensor changes data while clock high");
  chk_ack_release: assert property
    (sclFall && (first || !rw) && cnt == 4'h9 |-> $past(hostSdaEnN))
    else $error("host holds data in ack slot");
  chk_read_release: assert property
    (sclFall && rw && !first && cnt != 4'h9 |-> $past(hostSdaEnN))
    else $error("host drives data during read byte");
  chk_read_nack: assert property
    (sclFall && rw && !first && cnt == 4'h9 |-> $past(sda))
    else $error("read byte not left unacknowledged");
  chk_start_clock: assert property (startSeen |-> ##[1:12] !scl)
    else $error("clock not lowered after start");
  chk_clock_high: assert property (sclRise |=> scl [*8])
    else $error("clock high phase too short");
endmodule // tsn_link_chk

`default_nettype wire

// [tsn_link_if.sv]
/*
  Two-wire link between host and sensor: host-driven serial clock and
  an open-drain data line resolved here with a pull-up.
  Assumes each end drives data only low, enable low while pulling.
*/
`timescale 1ns/1ns
`default_nettype none

interface tsn_link_if;

  logic scl;
  logic hostSdaOut;
  logic hostSdaEnN;
  logic devSdaOut;
  logic devSdaEnN;
  logic sda;

  // wired-and data line with pull-up
  assign sda = ~((~hostSdaEnN & ~hostSdaOut) | (~devSdaEnN & ~devSdaOut));

  modport host (output scl, output hostSdaOut, output hostSdaEnN,
    input sda);
  modport dev (input scl, input sda, output devSdaOut, output devSdaEnN);

endinterface

`default_nettype wire

// [tsn_pkg.sv]
/*
  Types shared by both ends of the two-wire temperature sensor link.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package tsn_pkg;

  // sensor-side protocol states
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_ADDR = 3'b001,
    DS_CMD = 3'b010,
    DS_WDATA = 3'b011,
    DS_ACK = 3'b100,
    DS_TX = 3'b101,
    DS_MACK = 3'b110,
    DS_IGNORE = 3'b111
  } tsn_dev_state_e;

  // host bit-engine states
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_BYTE = 2'b10,
    HS_STOP = 2'b11
  } tsn_host_state_e;

  // which byte of a transfer the host is sending or receiving
  typedef enum logic [2:0] {
    ST_AW = 3'b000,
    ST_CMD = 3'b001,
    ST_WD = 3'b010,
    ST_AR = 3'b011,
    ST_RD = 3'b100
  } tsn_stage_e;

endpackage

`default_nettype wire

// [tsn_slave.sv]
/*
  Sensor end of the two-wire link: bus slave serving the temperature
  reading and the settings register, plus the converter handshake.
  Assumes the host drives the serial clock and the converter pulses
  convDone for one clock with a 10-bit signed degree count.
*/
// The plain strobed port is this design's own decision.
// Contract
// - ignore bus until a start condition
// - host sends address right after start
// - acknowledge only a matching 7-bit address
// - eighth address bit selects read or write
// - host writes command in first phase
// - host releases data for ninth clock
// - pull data low in ninth clock
// - host then writes data or clocks read
// - acknowledge every data byte written (only settings writes are acked here; temperature writes get a nack)
// - host ends transfers with stop condition
// - command 00h temperature, 01h settings
// - bit 7 standby, bits 5..0 zero
// - bit 6 ready, cleared entering standby (a conversion in the same cycle sets it here instead)
// - temperature is two's complement degrees
// - temperature updates after every conversion
// - both registers reset to zero
// - load temperature when ready rises
// - standby halts conversions, bus still works
// - read: command, repeated start, read, nack
// - bare read returns last commanded register
// - default address is 1001101b
`timescale 1ns/1ns
`default_nettype none
`include "tsn_defines.svh"

module tsn_slave
  import tsn_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic sys_rst,
  // two-wire link
  tsn_link_if.dev link,
  // address straps
  input wire logic addressSelectHigh,
  input wire logic addressSelectLow,
  // converter
  input wire logic [9:0] convResult,
  input wire logic convDone,
  output logic convRun,
  // register view
  output logic [7:0] temperature,
  output logic standby,
  output logic dataReady
);

  // saturate the converter's count to the signed 8-bit range
  function automatic logic [7:0] clampTemp(input logic [9:0] raw);
    logic [7:0] res;
    res = raw[7:0];
    if ($signed(raw) > $signed(`TSN_TEMP_HI))
      res = 8'(`TSN_TEMP_HI);
    else if ($signed(raw) < $signed(`TSN_TEMP_LO))
      res = 8'(`TSN_TEMP_LO);
    return res;
  endfunction

  logic sclS;
  logic sdaS;
  logic selHighS;
  logic selLowS;
  logic sclPrev;
  logic sdaPrev;
  tsn_dev_state_e state;
  tsn_dev_state_e next_state;
  tsn_dev_state_e after;
  tsn_dev_state_e next_after;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic ptrCfg;
  logic next_ptrCfg;
  logic driveLow;
  logic next_driveLow;
  logic wrStandby;

  // link pins and straps cross into the clock domain
  tsn_sync #(.W(4)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .din({link.scl, link.sda, addressSelectHigh, addressSelectLow}),
    .dout({sclS, sdaS, selHighS, selLowS})
  );

  // line events seen on the synchronised levels
  wire sclRise = sclS & ~sclPrev;
  wire sclFall = ~sclS & sclPrev;
  wire startSeen = sclS & sclPrev & sdaPrev & ~sdaS;
  wire stopSeen = sclS & sclPrev & ~sdaPrev & sdaS;
  wire [6:0] ownAddr = {`TSN_ADDR_FIXED, selHighS, selLowS};
  wire addrHit = (shift[7:1] == ownAddr);
  wire cmdTemp = (shift == `TSN_CMD_TEMP);
  wire cmdCfg = (shift == `TSN_CMD_CFG);
  wire byteDone = sclFall & (cnt == 4'h8);

  // register read selection, reserved bits zero
  wire [7:0] cfgView = {standby, dataReady, 6'h00};
  wire [7:0] readByte = ptrCfg ? cfgView : temperature;

  // protocol next-state decode
  always_comb
  begin
    next_state = state;
    next_after = after;
    next_cnt = cnt;
    next_shift = shift;
    next_ptrCfg = ptrCfg;
    next_driveLow = driveLow;
    wrStandby = 1'b0;
    if (stopSeen)
    begin
      next_state = DS_IDLE;
      next_driveLow = 1'b0;
    end
    else if (startSeen)
    begin
      next_state = DS_ADDR;
      next_cnt = 4'h0;
      next_driveLow = 1'b0;
    end
    else
    begin
      case (state)
        DS_ADDR, DS_CMD, DS_WDATA:
        begin
          if (sclRise)
          begin
            next_shift = {shift[6:0], sdaS};
            next_cnt = cnt + 4'h1;
          end
          else if (byteDone)
          begin
            next_state = DS_IGNORE;
            if (state == DS_ADDR && addrHit)
            begin
              next_state = DS_ACK;
              next_driveLow = 1'b1;
              next_after = shift[0] ? DS_TX : DS_CMD;
            end
            else if (state == DS_CMD && (cmdTemp || cmdCfg))
            begin
              next_state = DS_ACK;
              next_driveLow = 1'b1;
              next_ptrCfg = cmdCfg;
              next_after = DS_WDATA;
            end
            else if (state == DS_WDATA && ptrCfg)
            begin
              next_state = DS_ACK;
              next_driveLow = 1'b1;
              wrStandby = 1'b1;
              next_after = DS_WDATA;
            end
          end
        end
        DS_ACK:
        begin
          // hold data low through the ninth clock; on its fall release, or drive the first read bit
          if (sclFall)
          begin
            next_state = after;
            next_cnt = 4'h0;
            next_driveLow = 1'b0;
            if (after == DS_TX)
            begin
              next_shift = readByte;
              next_driveLow = ~readByte[7];
            end
          end
        end
        DS_TX:
        begin
          // next bit placed on the first seven falling clocks, msb first; the eighth releases data
          if (sclFall)
          begin
            if (cnt == 4'h7)
            begin
              next_state = DS_MACK;
              next_driveLow = 1'b0;
            end
            else
            begin
              next_shift = {shift[6:0], 1'b0};
              next_cnt = cnt + 4'h1;
              next_driveLow = ~shift[6];
            end
          end
        end
        DS_MACK:
        begin
          // a host nack ends the read, an ack repeats the byte
          if (sclRise && sdaS)
            next_state = DS_IGNORE;
          else if (sclFall)
          begin
            next_state = DS_TX;
            next_cnt = 4'h0;
            next_shift = readByte;
            next_driveLow = ~readByte[7];
          end
        end
        default:
        begin
          next_state = state;
        end
      endcase
    end
  end

  // protocol registers
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      state <= DS_IDLE;
      after <= DS_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      ptrCfg <= 1'b0;
      driveLow <= 1'b0;
    end
    else
    begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
      state <= next_state;
      after <= next_after;
      cnt <= next_cnt;
      shift <= next_shift;
      ptrCfg <= next_ptrCfg;
      driveLow <= next_driveLow;
    end
  end

  // settings, ready flag and temperature; a conversion beats the clear
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      standby <= 1'(`TSN_RST_CFG >> `TSN_CFG_STANDBY);
      dataReady <= 1'(`TSN_RST_CFG >> `TSN_CFG_READY);
      temperature <= `TSN_RST_TEMP;
    end
    else
    begin
      if (wrStandby)
        standby <= shift[`TSN_CFG_STANDBY];
      if (wrStandby && shift[`TSN_CFG_STANDBY] && !standby)
        dataReady <= 1'b0;
      if (convDone && !standby)
      begin
        dataReady <= 1'b1;
        temperature <= clampTemp(convResult);
      end
    end
  end

  // converter runs only outside standby
  assign convRun = ~standby;

  // open-drain data: value always low, enable low while pulling
  assign link.devSdaOut = 1'b0;
  assign link.devSdaEnN = ~driveLow;

endmodule // tsn_slave

`default_nettype wire

// [tsn_sync.sv]
/*
  Two-flop synchroniser for a group of asynchronous levels.
  Assumes the inputs idle high, so both stages reset to one.
*/
`timescale 1ns/1ns
`default_nettype none

module tsn_sync #(
  parameter int W = 1
) (
  // system
  input wire logic clock,
  input wire logic sys_rst,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // one pair of flops per bit; only the second stage is visible
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta;
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          meta <= 1'b1;
          dout[i] <= 1'b1;
        end
        else
        begin
          meta <= din[i];
          dout[i] <= meta;
        end
      end
    end
  endgenerate

endmodule // tsn_sync

`default_nettype wire
